// >>> verilog/stepper_pkg.sv
// constants, ratio table and off-time table for the stepper phase/current loader
package stepper_pkg;

    // ==========================================================
    // widths
    localparam int CH_N = 2;          // independent channels
    localparam int CMD_W = 4;         // bits per serial command
    localparam int CODE_W = 3;        // current-ratio code
    localparam int REF_W = 8;         // software reference level
    localparam int PM_W = 10;         // ratio in per mille
    localparam int LIM_W = REF_W + PM_W;
    localparam int OFF_W = 9;         // off-time counter
    localparam int ADDR_W = 4;        // avalon byte address
    localparam int DATA_W = 32;
    localparam int PIN_N = 9;         // synchronised pins

    // ==========================================================
    // register map (byte addresses, one word each)
    localparam logic [ADDR_W-1:0] ADDR_REF = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_LIMIT_A = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_LIMIT_B = 4'hC;
    localparam logic [REF_W-1:0] REF_RESET = 8'h80;

    // status word layout
    localparam int STAT_CH_W = 4;     // {code, phase} per channel
    localparam int STAT_DIS = 8;      // serial input disabled
    localparam int STAT_TRUE = 9;     // true-phase drives, one per channel
    localparam int STAT_COMP = 11;    // complementary drives
    localparam int STAT_OFF = 13;     // off-time running

    // ==========================================================
    // ratio codes
    localparam logic [CODE_W-1:0] CODE_ZERO = 3'h0;
    localparam logic [CODE_W-1:0] CODE_FULL = 3'h7;
    localparam logic [PM_W-1:0] PM_FULL = 10'h3E8;   // 100.0 %

    // ==========================================================
    // off time, nominal, rounded up to whole cycles
    localparam int CLK_MHZ = 40;
    localparam int NS_PER_US = 1000;
    localparam int OFF_SHORT_NS = 7000;
    localparam int OFF_MID_NS = 9000;
    localparam int OFF_LONG_NS = 11000;
    localparam logic [OFF_W-1:0] OFF_SHORT_CYC =
        OFF_W'((OFF_SHORT_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
    localparam logic [OFF_W-1:0] OFF_MID_CYC =
        OFF_W'((OFF_MID_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
    localparam logic [OFF_W-1:0] OFF_LONG_CYC =
        OFF_W'((OFF_LONG_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);

    // code to current ratio in per mille, ascending
    function automatic logic [PM_W-1:0] ratio_pm(input logic [CODE_W-1:0] code);
        unique case (code)
            3'h0: ratio_pm = 10'h000;
            3'h1: ratio_pm = 10'h0C8;
            3'h2: ratio_pm = 10'h190;
            3'h3: ratio_pm = 10'h22B;
            3'h4: ratio_pm = 10'h2CA;
            3'h5: ratio_pm = 10'h33E;
            3'h6: ratio_pm = 10'h38E;
            3'h7: ratio_pm = PM_FULL;
        endcase
    endfunction

    // code to chopper off time; the zero code shares the short time
    function automatic logic [OFF_W-1:0] off_cyc(input logic [CODE_W-1:0] code);
        unique case (code)
            3'h0, 3'h1, 3'h2: off_cyc = OFF_SHORT_CYC;
            3'h3, 3'h4, 3'h5: off_cyc = OFF_MID_CYC;
            3'h6, 3'h7: off_cyc = OFF_LONG_CYC;
        endcase
    endfunction

endpackage

// >>> verilog/loader_if.sv
// interface between the top level and one channel's serial loader
`timescale 1ns/10ps
interface loader_if;
    logic shift_fall;                          // one-cycle falling shift-clock edge
    logic latch_fall;                          // one-cycle falling latch edge
    logic data;                                // synchronised serial data
    logic disabled;                            // reference/enable high
    logic phase;                               // latched phase select
    logic [stepper_pkg::CODE_W-1:0] code;      // latched ratio code

    modport loader(input shift_fall, input latch_fall, input data, input disabled,
                   output phase, output code);
    modport ctrl(output shift_fall, output latch_fall, output data, output disabled,
                 input phase, input code);
endinterface

// >>> verilog/pin_sync2.sv
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
module pin_sync2 #(
    parameter int W = 1
) (
    input logic clk,
    input logic sys_rst,
    input logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out
);
    // ==========================================================
    // state: first stage is read only by the second
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_s;

    sync_s st;       // registered
    sync_s next_st;  // next value

    // shift the pins one stage per clock
    always_comb begin
        next_st = st;
        next_st.s1 = pin_in;
        next_st.s2 = st.s1;
    end

    // register the state
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pin_out = st.s2;
endmodule

// >>> verilog/phase_ratio_loader.sv
// four-bit serial shift register and output latch for one channel
`timescale 1ns/10ps
module phase_ratio_loader (
    input logic clk,
    input logic sys_rst,
    loader_if.loader bus
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [stepper_pkg::CMD_W-1:0] shreg;   // newest bit at the top
        logic phase;                            // active phase
        logic [stepper_pkg::CODE_W-1:0] code;   // active ratio code
    } ld_s;

    ld_s st;
    ld_s next_st;

    // shift, latch and clear
    always_comb begin
        next_st = st;
        if (bus.disabled) begin
            // disable clears everything and blocks the pins
            next_st = '0;
        end else begin
            // after four shifts bit 0 is the phase, bits 3:1 the code lsb first
            if (bus.shift_fall) begin
                next_st.shreg = {bus.data, st.shreg[stepper_pkg::CMD_W-1:1]};
            end
            // a shift in the latch cycle is not seen by the latch
            if (bus.latch_fall) begin
                next_st.phase = st.shreg[0];
                next_st.code = st.shreg[stepper_pkg::CMD_W-1:1];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bus.phase = st.phase;
    assign bus.code = st.code;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence en_shift;
        !bus.disabled && bus.shift_fall;
    endsequence

    sequence en_latch;
        !bus.disabled && bus.latch_fall;
    endsequence

    a_shift_capture: assert property (en_shift |=>
        st.shreg == {$past(bus.data), $past(st.shreg[stepper_pkg::CMD_W-1:1])})
        else $error("shift register missed a falling shift edge");

    a_latch_copy: assert property (en_latch |=>
        bus.code == $past(st.shreg[stepper_pkg::CMD_W-1:1]) && bus.phase == $past(st.shreg[0]))
        else $error("latch did not copy the shift register");

    a_four_bit_cmd: assert property ((en_shift ##1 en_shift ##1 en_shift ##1 en_shift
        ##1 (en_latch and !bus.shift_fall)) |=> bus.phase == $past(bus.data, 5))
        else $error("first of four bits is not the phase");

    a_disable_clear: assert property (bus.disabled |=>
        st.shreg == '0 && bus.code == '0 && !bus.phase)
        else $error("disable did not clear the loader");

    a_disabled_hold: assert property (bus.disabled [*2] |=> $stable(st))
        else $error("loader changed while disabled");
endmodule

// >>> verilog/stepper_loader_top.sv
// two-channel serial phase/current loader with avalon-mm register access
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps

// Contract
// - shift data in on falling shift edges
// - four bits: phase first, then code
// - phase high drives true, low complementary
// - code bits arrive lsb first, msb last
// - code selects ratio and chopper off time
// - falling latch edge makes shifted command active
// - serial input enabled only while enable low
// - enable high disables input, outputs off
// - while disabled, pin activity changes nothing
// - code 111 gives full-scale ratio
// - current limit tracks reference times ratio
// - disable clears shift register and latch
// - codes map to eight ascending ratios
// - channels independent, own register and latch
module stepper_loader_top (
    input logic clk,
    input logic sys_rst,
    input logic [stepper_pkg::ADDR_W-1:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [stepper_pkg::DATA_W-1:0] avs_writedata,
    output logic [stepper_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input logic ref_disable,
    input logic [stepper_pkg::CH_N-1:0] ser_data,
    input logic [stepper_pkg::CH_N-1:0] shift_clk,
    input logic [stepper_pkg::CH_N-1:0] latch_pulse,
    input logic [stepper_pkg::CH_N-1:0] sense_trip,
    output logic [stepper_pkg::CH_N-1:0] drive_true,
    output logic [stepper_pkg::CH_N-1:0] drive_comp,
    output logic [stepper_pkg::LIM_W-1:0] limit_a,
    output logic [stepper_pkg::LIM_W-1:0] limit_b
);
    // ==========================================================
    // state of the top level
    typedef struct packed {
        logic ack;                                          // bus answer phase
        logic [stepper_pkg::DATA_W-1:0] rdata;              // read data register
        logic [stepper_pkg::REF_W-1:0] ref_level;           // reference level
        logic [stepper_pkg::CH_N-1:0] sclk_d;               // last shift clock level
        logic [stepper_pkg::CH_N-1:0] latch_d;              // last latch level
        logic [stepper_pkg::CH_N-1:0] trip_d;               // last trip level
        logic [stepper_pkg::CH_N-1:0] drv_true;             // true-phase drive
        logic [stepper_pkg::CH_N-1:0] drv_comp;             // complementary drive
        logic [stepper_pkg::CH_N-1:0][stepper_pkg::OFF_W-1:0] off_cnt;   // chopper off
        logic [stepper_pkg::CH_N-1:0][stepper_pkg::LIM_W-1:0] limit;     // current limit
    } top_s;

    top_s st;       // registered
    top_s next_st;  // next value

    // ==========================================================
    // pin synchronisation
    logic [stepper_pkg::PIN_N-1:0] pins_raw;   // pins as they arrive
    logic [stepper_pkg::PIN_N-1:0] pins_s;     // after two flops
    logic dis_s;                               // reference/enable above the enable band
    logic [stepper_pkg::CH_N-1:0] data_s;      // serial data
    logic [stepper_pkg::CH_N-1:0] sclk_s;      // shift clock
    logic [stepper_pkg::CH_N-1:0] latch_s;     // latch pulse
    logic [stepper_pkg::CH_N-1:0] trip_s;      // current trip from sense comparator

    // one bundle so every pin sees the same delay; data and clock stay aligned
    assign pins_raw = {sense_trip, latch_pulse, shift_clk, ser_data, ref_disable};

    pin_sync2 #(
        .W(stepper_pkg::PIN_N)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in(pins_raw),
        .pin_out(pins_s)
    );

    // unpack the synchronised bundle
    assign {trip_s, latch_s, sclk_s, data_s, dis_s} = pins_s;

    // ==========================================================
    // edge detection, read only from the second flop
    logic [stepper_pkg::CH_N-1:0] shift_fall;   // falling shift clock
    logic [stepper_pkg::CH_N-1:0] latch_fall;   // falling latch pulse
    logic [stepper_pkg::CH_N-1:0] trip_rise;    // start of a current trip

    assign shift_fall = st.sclk_d & ~sclk_s;
    assign latch_fall = st.latch_d & ~latch_s;
    assign trip_rise = ~st.trip_d & trip_s;

    // ==========================================================
    // channel loaders, one per channel; only the disable is shared
    logic [stepper_pkg::CH_N-1:0] ch_phase;                        // active phase
    logic [stepper_pkg::CH_N-1:0][stepper_pkg::CODE_W-1:0] ch_code; // active code

    for (genvar g = 0; g < stepper_pkg::CH_N; g++) begin : g_ch
        loader_if lif();

        // edges are gated by the enable inside the loader
        assign lif.shift_fall = shift_fall[g];
        assign lif.latch_fall = latch_fall[g];
        assign lif.data = data_s[g];
        assign lif.disabled = dis_s;

        phase_ratio_loader u_ld (
            .clk(clk),
            .sys_rst(sys_rst),
            .bus(lif.loader)
        );

        assign ch_phase[g] = lif.phase;
        assign ch_code[g] = lif.code;
    end

    // ==========================================================
    // register read mux
    function automatic logic [stepper_pkg::DATA_W-1:0] reg_read(
        input logic [stepper_pkg::ADDR_W-1:0] addr,
        input top_s s,
        input logic dis,
        input logic [stepper_pkg::CH_N-1:0] ph,
        input logic [stepper_pkg::CH_N-1:0][stepper_pkg::CODE_W-1:0] cd
    );
        logic [stepper_pkg::DATA_W-1:0] rd;
        rd = '0;
        unique case (addr)
            stepper_pkg::ADDR_REF: begin
                rd[stepper_pkg::REF_W-1:0] = s.ref_level;
            end
            stepper_pkg::ADDR_STATUS: begin
                // per channel nibble: code above phase
                for (int i = 0; i < stepper_pkg::CH_N; i++) begin
                    rd[i*stepper_pkg::STAT_CH_W +: stepper_pkg::STAT_CH_W] = {cd[i], ph[i]};
                    rd[stepper_pkg::STAT_OFF + i] = |s.off_cnt[i];
                end
                rd[stepper_pkg::STAT_DIS] = dis;
                rd[stepper_pkg::STAT_TRUE +: stepper_pkg::CH_N] = s.drv_true;
                rd[stepper_pkg::STAT_COMP +: stepper_pkg::CH_N] = s.drv_comp;
            end
            stepper_pkg::ADDR_LIMIT_A: begin
                rd[stepper_pkg::LIM_W-1:0] = s.limit[0];
            end
            stepper_pkg::ADDR_LIMIT_B: begin
                rd[stepper_pkg::LIM_W-1:0] = s.limit[1];
            end
            default: begin
                // unmapped words read as zero
                rd = '0;
            end
        endcase
        return rd;
    endfunction

    // ==========================================================
    // next-state logic
    always_comb begin
        next_st = st;

        // every access waits exactly one cycle; the answer never depends on the pins
        next_st.ack = (avs_read | avs_write) & ~st.ack;

        // read data captured in the wait cycle, held until the next read
        if (avs_read && !st.ack) begin
            next_st.rdata = reg_read(avs_address, st, dis_s, ch_phase, ch_code);
        end

        // write takes effect in the answer cycle only; other words are read-only
        if (avs_write && st.ack && avs_address == stepper_pkg::ADDR_REF) begin
            next_st.ref_level = avs_writedata[stepper_pkg::REF_W-1:0];
        end

        // pin history for edge detection
        next_st.sclk_d = sclk_s;
        next_st.latch_d = latch_s;
        next_st.trip_d = trip_s;

        for (int i = 0; i < stepper_pkg::CH_N; i++) begin
            if (dis_s) begin
                // disabled: no drive, no limit, no chopping
                next_st.off_cnt[i] = '0;
                next_st.limit[i] = '0;
                next_st.drv_true[i] = 1'b0;
                next_st.drv_comp[i] = 1'b0;
            end else begin
                // limit follows reference times ratio; the full code gives full scale
                next_st.limit[i] = stepper_pkg::LIM_W'(st.ref_level
                    * stepper_pkg::ratio_pm(ch_code[i]));

                // a trip starts the off time chosen by the active code
                if (trip_rise[i] && st.off_cnt[i] == '0) begin
                    next_st.off_cnt[i] = stepper_pkg::off_cyc(ch_code[i]);
                end else if (st.off_cnt[i] != '0) begin
                    next_st.off_cnt[i] = st.off_cnt[i] - 1'b1;
                end

                // the zero ratio leaves both drives off; chopping gates them too
                if (ch_code[i] != stepper_pkg::CODE_ZERO && st.off_cnt[i] == '0) begin
                    next_st.drv_true[i] = ch_phase[i];
                    next_st.drv_comp[i] = ~ch_phase[i];
                end else begin
                    next_st.drv_true[i] = 1'b0;
                    next_st.drv_comp[i] = 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // state register; the reference level comes up mid-scale
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
            st.ref_level <= stepper_pkg::REF_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs
    assign avs_waitrequest = (avs_read | avs_write) & ~st.ack;
    assign avs_readdata = st.rdata;
    assign drive_true = st.drv_true;
    assign drive_comp = st.drv_comp;
    assign limit_a = st.limit[0];
    assign limit_b = st.limit[1];

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence bus_wait;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    a_bus_answer: assert property (bus_wait ##1 (avs_read || avs_write) |-> !avs_waitrequest)
        else $error("bus answer not given after one wait cycle");

    a_ref_write: assert property (avs_write && !avs_waitrequest
        && avs_address == stepper_pkg::ADDR_REF
        |=> st.ref_level == $past(avs_writedata[stepper_pkg::REF_W-1:0]))
        else $error("reference write not stored");

    a_disable_off: assert property (dis_s |=> drive_true == '0 && drive_comp == '0)
        else $error("drives on while disabled");

    a_drive_phase: assert property (!dis_s && ch_code[0] != stepper_pkg::CODE_ZERO
        && st.off_cnt[0] == '0 |=> drive_true[0] == $past(ch_phase[0])
        && drive_comp[0] == !$past(ch_phase[0]))
        else $error("phase select drove the wrong output");

    a_full_limit: assert property (!dis_s && ch_code[1] == stepper_pkg::CODE_FULL
        |=> limit_b == stepper_pkg::LIM_W'($past(st.ref_level) * stepper_pkg::PM_FULL))
        else $error("full code did not give full scale");

    a_limit_track: assert property (!dis_s |=> limit_a == stepper_pkg::LIM_W'(
        $past(st.ref_level) * stepper_pkg::ratio_pm($past(ch_code[0]))))
        else $error("limit does not follow reference times ratio");

    a_off_load: assert property (!dis_s && trip_rise[0] && st.off_cnt[0] == '0
        |=> st.off_cnt[0] == stepper_pkg::off_cyc($past(ch_code[0]))
        ##1 drive_true[0] == 1'b0 && drive_comp[0] == 1'b0)
        else $error("off time not started from the code");
endmodule

// >>> verif/step_ctrl_model.sv
// far-side controller model: shifts serial commands and pulses the latch
`timescale 1ns/10ps
module step_ctrl_model (
    input wire logic clk,
    output logic [1:0] ser_data,
    output logic [1:0] shift_clk,
    output logic [1:0] latch_pulse
);
    // ==========================================
    // link timing
    localparam int HALF = 4;    // half link period in clk cycles (200 ns period)

    // idle levels; the shift clock stands low between frames
    initial begin
        ser_data = 2'h0;
        shift_clk = 2'h0;
        latch_pulse = 2'h0;
    end

    // ==========================================
    // shifts n bits of v, v[0] first, each taken on a falling shift edge
    task automatic shift(input int ch, input int n, input logic [7:0] v);
        for (int i = 0; i < n; i++) begin
            ser_data[ch] <= v[i];
            shift_clk[ch] <= 1'b1;
            repeat (HALF) @(posedge clk);
            shift_clk[ch] <= 1'b0;
            repeat (3) @(posedge clk);
            // hold over: the line no longer shows the last bit
            ser_data[ch] <= ~v[i];
            @(posedge clk);
        end
    endtask

    // latch pulse, issued after a shifted command or, in the disable test, on its own
    task automatic latch(input int ch);
        latch_pulse[ch] <= 1'b1;
        repeat (HALF) @(posedge clk);
        latch_pulse[ch] <= 1'b0;
        repeat (HALF) @(posedge clk);
    endtask
endmodule

// >>> verif/stepper_serial_phase_current_loader_bench.sv
// self-checking bench for the two-channel serial phase/current loader
`timescale 1ns/10ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[ERR] %0t mismatch got %0h exp %0h", $time, got, exp); end end
module stepper_serial_phase_current_loader_bench;
    // ==========================================
    // signals
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ref_disable = 1'b0;           // high disables the serial input
    logic [1:0] ser_data, shift_clk, latch_pulse;
    logic [1:0] sense_trip = 2'h0;
    logic [1:0] drive_true, drive_comp;
    logic [17:0] limit_a, limit_b;
    logic [31:0] q;                     // last read word
    int error_cnt = 0;
    int n_checks = 0;
    int pm [8] = '{0, 200, 400, 555, 714, 830, 910, 1000};  // ratio per mille

    // 40 MHz clock
    always #12.5 clk = ~clk;

    stepper_loader_top dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ref_disable(ref_disable), .ser_data(ser_data), .shift_clk(shift_clk),
        .latch_pulse(latch_pulse), .sense_trip(sense_trip), .drive_true(drive_true),
        .drive_comp(drive_comp), .limit_a(limit_a), .limit_b(limit_b));

    step_ctrl_model ctrl (.clk(clk), .ser_data(ser_data), .shift_clk(shift_clk),
        .latch_pulse(latch_pulse));

    // ==========================================
    // avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge clk);
        // only the watchdog ends a wait that never gets its answer
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    // shift n bits, latch, then let the result settle
    task automatic load(input int ch, input int n, input logic [7:0] v);
        ctrl.shift(ch, n, v);
        ctrl.latch(ch);
        repeat (6) @(posedge clk);
    endtask

    // active phase/code of one channel and its drives; a zero code drives nothing
    task automatic chk_ch(input int ch, input logic [3:0] v);
        bus(1'b0, stepper_pkg::ADDR_STATUS, 32'h0);
        `CHK(q[ch*4 +: 4], v)
        `CHK(drive_true[ch], v[0] & (v[3:1] != 3'h0))
        `CHK(drive_comp[ch], ~v[0] & (v[3:1] != 3'h0))
    endtask

    // ==========================================
    // scenarios
    task automatic t_regs;
        bus(1'b0, stepper_pkg::ADDR_REF, 32'h0);
        `CHK(q, 32'h80)
        bus(1'b1, stepper_pkg::ADDR_STATUS, 32'hFFFF);
        bus(1'b0, 4'h2, 32'h0);
        `CHK(q, 32'h0)
        chk_ch(0, 4'h0);
        $display("test regs done");
    endtask

    // every code and both phases; limit follows reference times ratio
    task automatic t_codes;
        logic [3:0] v;
        bus(1'b1, stepper_pkg::ADDR_REF, 32'hC5);
        for (int c = 0; c < 8; c++) begin
            v = {c[2:0], c[0]};
            load(0, 4, {4'h0, v});
            chk_ch(0, v);
            `CHK(limit_a, 18'(197 * pm[c]))
            bus(1'b0, stepper_pkg::ADDR_LIMIT_A, 32'h0);
            `CHK(q, 32'(197 * pm[c]))
        end
        $display("test codes done");
    endtask

    // six bits into B keep only the last four; A is untouched
    task automatic t_extra;
        load(1, 6, 8'b0010_1101);
        chk_ch(1, 4'hB);
        `CHK(limit_b, 18'(197 * pm[5]))
        bus(1'b0, stepper_pkg::ADDR_LIMIT_B, 32'h0);
        `CHK(q, 32'(197 * pm[5]))
        chk_ch(0, 4'hF);
        $display("test extra done");
    endtask

    // disable clears everything and ignores pin activity
    task automatic t_disable;
        ref_disable <= 1'b1;
        repeat (8) @(posedge clk);
        load(0, 4, 8'h0F);
        bus(1'b0, stepper_pkg::ADDR_STATUS, 32'h0);
        `CHK(q[8:0], 9'h100)
        `CHK(drive_true | drive_comp, 2'h0)
        `CHK(limit_a | limit_b, 18'h0)
        ref_disable <= 1'b0;
        repeat (8) @(posedge clk);
        ctrl.latch(0);
        repeat (6) @(posedge clk);
        chk_ch(0, 4'h0);
        $display("test disable done");
    endtask

    // trip starts the short off time of code 1: 280 cycles with drives off
    task automatic t_offtime;
        load(0, 4, 8'h03);
        chk_ch(0, 4'h3);
        sense_trip <= 2'h1;
        repeat (10) @(posedge clk);
        `CHK(drive_true[0], 1'b0)
        bus(1'b0, stepper_pkg::ADDR_STATUS, 32'h0);
        `CHK(q[14:13], 2'h1)
        sense_trip <= 2'h0;
        repeat (250) @(posedge clk);
        `CHK(drive_true[0], 1'b0)
        repeat (40) @(posedge clk);
        `CHK(drive_true[0], 1'b1)
        // code 7 selects the long off time: 440 cycles
        load(0, 4, 8'h0F);
        sense_trip <= 2'h1;
        repeat (430) @(posedge clk);
        `CHK(drive_true[0], 1'b0)
        sense_trip <= 2'h0;
        repeat (20) @(posedge clk);
        `CHK(drive_true[0], 1'b1)
        $display("test offtime done");
    endtask

    // ==========================================
    // verdict
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // watchdog: the run needs well under 8000 cycles
    initial begin
        #400000;
        error_cnt++;
        test_done();
    end

    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_regs();
        t_codes();
        t_extra();
        t_disable();
        t_offtime();
        test_done();
    end
endmodule
